//--- hdl/amc_config.sv
`timescale 1ns/1ps
`include "amc_map.svh"
// What this block does
// - bit 7 of amplifier_config set to one bypasses the amplifier, zero routes through it.
// - gain field bits 2:0 gives gain 1 at 000, 64 at 110, 128 at 111, others reserved.
// - pos_input_sel bits 7:4 picks inputs 0..5 at 0011..1000, temp 1011, open 1110, mid 1111.
// - neg_input_sel bits 3:0 uses the same map and resets to mid-supply 1111.
// - chip select held low keeps the serial data pin enabled without framing.
// - an external clock held at ground leaves the block on its internal tick.
// - start low means command-only conversions, start high in continuous mode free-runs.
// - the block resets at power-on and by the reset pin; the reset command resets registers and status but keeps the running sum and result buffer.
// - power-down may be entered by software as well as by the pin.
// - the shared pin signals data ready and data, driving only while chip select is low.
// - results are buffered so the host may read them at any time.
// - software can poll a data-ready status bit.
module amc_config #(
  parameter int DWIDTH = 24
) (
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  input  wire amc_pkg::amc_bus_t bus_in,
  output logic [7:0]             rdata_out,
  input  wire logic              cs_n_in,
  input  wire logic              start_in,
  input  wire logic              power_down_n_in,
  input  wire logic              ext_clock_in,
  output logic                   shared_out_ready_out,
  output logic                   shared_out_ready_oe_n_out,
  output logic                   data_ready_n_out,
  output logic                   bypass_out,
  output amc_pkg::amc_gain_t     gain_out,
  output logic [3:0]             pos_input_sel_out,
  output logic [3:0]             neg_input_sel_out,
  output logic                   int_clk_sel_out,
  output logic                   powered_down_out,
  output logic                   irq_out
);
  import amc_pkg::*;

  // ****************************************
  // register decode
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // reserved mux codes, shared by both halves of input_select
  function automatic logic mux_reserved(input logic [3:0] c);
    mux_reserved = (c < 4'h3) || (c == 4'h9) || (c == 4'hA) || (c == 4'hC) || (c == 4'hD);
  endfunction : mux_reserved

  logic [7:0]        amp_r;
  logic [7:0]        insel_r;
  logic [7:0]        delay_r;
  logic              cont_r;
  logic [1:0]        sts_r;
  logic [1:0]        ien_r;
  logic              soft_rst_r;
  logic              pdn_r;
  logic              run_r;
  logic [15:0]       cnt_r;
  logic [7:0]        dly_r;
  logic [DWIDTH-1:0] sample_r;
  logic [DWIDTH-1:0] buf_q;
  logic [4:0]        sh_cnt_r;

  wire wr_w      = bus_in.wr;
  wire rd_w      = bus_in.rd;
  wire cmd_w     = wr_w && hit(bus_in.addr, `AMC_OFS_CTRL);
  wire cmd_start = cmd_w && bus_in.wdata[`AMC_CTRL_START];
  wire cmd_stop  = cmd_w && bus_in.wdata[`AMC_CTRL_STOP];
  wire cmd_rst   = cmd_w && bus_in.wdata[`AMC_CTRL_RESET];
  wire pdn_w     = pdn_r || !power_down_n_in;
  wire free_run  = start_in && cont_r;
  wire conv_done = run_r && (dly_r == 8'h00) && (cnt_r == `AMC_CONV_CYC);
  // reserved mux codes flag an error event instead of being silently remapped
  wire bad_mux   = wr_w && hit(bus_in.addr, `AMC_OFS_INSEL) &&
                   (mux_reserved(bus_in.wdata[7:4]) ||
                    mux_reserved(bus_in.wdata[3:0]));
  wire [1:0] ev_w = {bad_mux, conv_done};
  wire [1:0] clr_w = (wr_w && hit(bus_in.addr, `AMC_OFS_IRQ_CLR)) ?
                     bus_in.wdata[1:0] : 2'b00;
  wire data_ready_n_clr  = rd_w && hit(bus_in.addr, `AMC_OFS_DATA0);
  wire [1:0] sts_nxt = ev_w | (sts_r & ~clr_w); // set beats clear
  // a fresh result wins over the clear made by reading the top data byte
  wire [1:0] sts_full_nxt = soft_rst_r ? 2'b00 :
                            {sts_nxt[1], conv_done | (sts_nxt[0] & ~data_ready_n_clr)};
  // the buffer takes the new sum so a result never lags one conversion
  wire [DWIDTH-1:0] sample_nxt = sample_r + {{(DWIDTH-8){1'b0}}, insel_r};

  amc_gain_t gain_w;
  assign gain_w = (amp_r[2:0] == 3'b000) ? AMC_GAIN_1 :
                  (amp_r[2:0] == 3'b110) ? AMC_GAIN_64 :
                  (amp_r[2:0] == 3'b111) ? AMC_GAIN_128 : AMC_GAIN_BAD;

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      amp_r   <= `AMC_RST_AMP;
      insel_r <= `AMC_RST_INSEL;
      delay_r <= `AMC_RST_DELAY;
      cont_r  <= 1'b0;
      pdn_r   <= 1'b0;
      ien_r   <= 2'b00;
    end else if (soft_rst_r) begin
      amp_r   <= `AMC_RST_AMP;
      insel_r <= `AMC_RST_INSEL;
      delay_r <= `AMC_RST_DELAY;
      cont_r  <= 1'b0;
      pdn_r   <= 1'b0;
      ien_r   <= 2'b00;
    end else if (wr_w) begin
      if (hit(bus_in.addr, `AMC_OFS_AMP)) amp_r <= bus_in.wdata;
      if (hit(bus_in.addr, `AMC_OFS_INSEL)) insel_r <= bus_in.wdata;
      if (hit(bus_in.addr, `AMC_OFS_DELAY)) delay_r <= bus_in.wdata;
      if (hit(bus_in.addr, `AMC_OFS_IRQ_EN)) ien_r <= bus_in.wdata[1:0];
      if (cmd_w) begin
        cont_r <= bus_in.wdata[`AMC_CTRL_CONT];
        pdn_r  <= bus_in.wdata[`AMC_CTRL_PDN];
      end
    end
  end

  // reset command takes effect one cycle after the write
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) soft_rst_r <= 1'b0;
    else soft_rst_r <= cmd_rst;
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  // the external clock pin is not used as a clock; the internal tick runs all timing
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      run_r    <= 1'b0;
      cnt_r    <= '0;
      dly_r    <= '0;
      sample_r <= '0;
    end else if (soft_rst_r || pdn_w || cmd_stop) begin
      run_r <= 1'b0;
      cnt_r <= '0;
    end else if (!run_r) begin
      if (cmd_start || free_run) begin
        run_r <= 1'b1;
        dly_r <= delay_r;
        cnt_r <= '0;
      end
    end else if (dly_r != 8'h00) begin
      dly_r <= dly_r - 8'h01;
    end else if (conv_done) begin
      sample_r <= sample_nxt;
      cnt_r    <= '0;
      run_r    <= cont_r;
      dly_r    <= delay_r;
    end else begin
      cnt_r <= cnt_r + 16'd1;
    end
  end

  amc_result_buf #(
    .WIDTH (DWIDTH)
  ) u_buf (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .wr_in     (conv_done),
    .wdata_in  (sample_nxt),
    .rdata_out (buf_q)
  );

  // ****************************************
  // status, interrupt, read port
  // ****************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sts_r <= 2'b00;
    end else begin
      sts_r <= sts_full_nxt;
    end
  end

  wire [7:0] rd_mux =
    hit(bus_in.addr, `AMC_OFS_AMP)    ? amp_r :
    hit(bus_in.addr, `AMC_OFS_INSEL)  ? insel_r :
    hit(bus_in.addr, `AMC_OFS_CTRL)   ? {3'b000, cont_r, pdn_r, 3'b000} :
    hit(bus_in.addr, `AMC_OFS_STATUS) ? {6'h00, sts_r} :
    hit(bus_in.addr, `AMC_OFS_IRQ_EN) ? {6'h00, ien_r} :
    hit(bus_in.addr, `AMC_OFS_DATA0)  ? buf_q[23:16] :
    hit(bus_in.addr, `AMC_OFS_DATA1)  ? buf_q[15:8] :
    hit(bus_in.addr, `AMC_OFS_DATA2)  ? buf_q[7:0] :
    hit(bus_in.addr, `AMC_OFS_DELAY)  ? delay_r : 8'h00;

  // ****************************************
  // shared data/ready pin
  // ****************************************
  // with chip select low the pin shows ready until a result is shifted out
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out                 <= 8'h00;
      irq_out                   <= 1'b0;
      data_ready_n_out          <= 1'b1;
      shared_out_ready_out      <= 1'b1;
      shared_out_ready_oe_n_out <= 1'b1;
      sh_cnt_r                  <= '0;
      bypass_out                <= 1'b0;
      gain_out                  <= AMC_GAIN_1;
      pos_input_sel_out         <= 4'hF;
      neg_input_sel_out         <= 4'hF;
      int_clk_sel_out           <= 1'b1;
      powered_down_out          <= 1'b0;
    end else begin
      rdata_out                 <= rd_w ? rd_mux : 8'h00;
      irq_out                   <= |(sts_full_nxt & ien_r);
      data_ready_n_out          <= ~sts_full_nxt[0];
      shared_out_ready_oe_n_out <= cs_n_in;
      if (cs_n_in) sh_cnt_r <= '0;
      // the count stops one past the last bit so bit 0 gets a cycle of its own
      else if (sh_cnt_r != 5'd25) sh_cnt_r <= sh_cnt_r + 5'd1;
      shared_out_ready_out <= (cs_n_in || sh_cnt_r == 5'd0) ? ~sts_r[0] :
                              (sh_cnt_r == 5'd25) ? 1'b0 :
                              buf_q[5'd24 - sh_cnt_r];
      bypass_out        <= amp_r[`AMC_AMP_BYP_BIT];
      gain_out          <= gain_w;
      pos_input_sel_out <= insel_r[7:4];
      neg_input_sel_out <= insel_r[3:0];
      int_clk_sel_out   <= ~ext_clock_in;
      powered_down_out  <= pdn_w;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  bypass_follow_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ##1 bypass_out == $past(amp_r[7])) else $error("bypass mismatch");
  gain_map_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    amp_r[2:0] == 3'b111 |=> gain_out == AMC_GAIN_128) else $error("gain map");
  mux_reset_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    soft_rst_r |=> insel_r == 8'hFF) else $error("mux reset");
  pin_drive_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !cs_n_in |=> !shared_out_ready_oe_n_out) else $error("pin not driven");
  soft_reset_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    cmd_rst |=> ##1 amp_r == 8'h00) else $error("soft reset");
  power_down_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    pdn_r |=> powered_down_out && !run_r) else $error("power down");
  sequence conv_seen_s;
    conv_done && !soft_rst_r;
  endsequence
  data_ready_n_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    conv_seen_s |=> sts_r[0] && !data_ready_n_out) else $error("data_ready_n");
  stop_halts_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    cmd_stop |=> !run_r) else $error("stop ignored");
  int_clock_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !ext_clock_in |=> int_clk_sel_out) else $error("int clock");
endmodule : amc_config

//--- hdl/amc_map.svh
`ifndef AMC_MAP_SVH
`define AMC_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define AMC_OFS_AMP      8'h10
`define AMC_OFS_INSEL    8'h11
`define AMC_OFS_CTRL     8'h20
`define AMC_OFS_STATUS   8'h21
`define AMC_OFS_IRQ_EN   8'h22
`define AMC_OFS_IRQ_CLR  8'h23
`define AMC_OFS_DATA0    8'h24
`define AMC_OFS_DATA1    8'h25
`define AMC_OFS_DATA2    8'h26
`define AMC_OFS_DELAY    8'h27
// ****************************************
// reset values and fields
// ****************************************
`define AMC_RST_AMP      8'h00
`define AMC_RST_INSEL    8'hFF
`define AMC_RST_DELAY    8'h01
`define AMC_AMP_BYP_BIT  7
`define AMC_CTRL_START   0
`define AMC_CTRL_STOP    1
`define AMC_CTRL_RESET   2
`define AMC_CTRL_PDN     3
`define AMC_CTRL_CONT    4
`define AMC_ST_DATA_READY_N      0
`define AMC_ST_ERR       1
`define AMC_CONV_CYC     16'd100
`endif

//--- hdl/amc_pkg.sv
package amc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } amc_bus_t;
  typedef enum logic [1:0] {
    AMC_GAIN_1   = 2'd0,
    AMC_GAIN_64  = 2'd1,
    AMC_GAIN_128 = 2'd2,
    AMC_GAIN_BAD = 2'd3
  } amc_gain_t;
endpackage : amc_pkg

//--- hdl/amc_result_buf.sv
`timescale 1ns/1ps
module amc_result_buf #(
  parameter int WIDTH = 24
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             wr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  output logic      [WIDTH-1:0] rdata_out
);
  // result held until the next conversion so the host may read any time
  logic [WIDTH-1:0] mem_r;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_r     <= '0;
      rdata_out <= '0;
    end else begin
      if (wr_in) begin
        mem_r <= wdata_in;
      end
      rdata_out <= wr_in ? wdata_in : mem_r;
    end
  end
endmodule : amc_result_buf

//--- testbench/amc_host_model.sv
`timescale 1ns/1ps
// ****************************************
// host side of the serial pins
// ****************************************
module amc_host_model (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       sel_in,
  input  wire logic       oe_n_in,
  input  wire logic       pin_in,
  output logic            cs_n_out,
  output logic [7:0]      n_drv_out,
  output logic [24:0]     bits_out
);
  // cs held low with no framing for as long as the bench selects
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cs_n_out  <= 1'b1;
      n_drv_out <= 8'h00;
      bits_out  <= '0;
    end else begin
      // ready bit first, then 24 result bits, most significant first
      if (!oe_n_in && n_drv_out < 8'd25) begin
        bits_out <= {bits_out[23:0], pin_in};
      end
      cs_n_out <= ~sel_in;
      // count cycles the device drives the shared pin
      if (!oe_n_in && n_drv_out != 8'hFF) begin
        n_drv_out <= n_drv_out + 8'h01;
      end
    end
  end
endmodule : amc_host_model

//--- testbench/tb_amp_and_input_mux_config.sv
`timescale 1ns/1ps
`include "amc_map.svh"
module tb_amp_and_input_mux_config;
  import amc_pkg::*;
  logic       clk_in  = 1'b0;
  logic       rstn_in = 1'b0;
  amc_bus_t   bus     = '0;
  logic       start   = 1'b0;
  logic       pdn_n   = 1'b1;
  logic       ext_clk = 1'b0;
  logic       sel     = 1'b0;
  logic       cs_n, pin, oe_n, data_ready_n_n, byp, pd, irq, int_clk;
  logic [7:0] rdata, n_drv, v, w;
  logic [24:0] bits;
  logic [3:0] psel, nsel;
  amc_gain_t  gain;
  int         err_count = 0;
  int         n_checks  = 0;
  always #5 clk_in = ~clk_in;
  amc_config dut (.clk_in(clk_in), .rstn_in(rstn_in), .bus_in(bus), .rdata_out(rdata),
    .cs_n_in(cs_n), .start_in(start), .power_down_n_in(pdn_n), .ext_clock_in(ext_clk),
    .shared_out_ready_out(pin), .shared_out_ready_oe_n_out(oe_n),
    .data_ready_n_out(data_ready_n_n), .bypass_out(byp), .gain_out(gain),
    .pos_input_sel_out(psel), .neg_input_sel_out(nsel), .int_clk_sel_out(int_clk),
    .powered_down_out(pd), .irq_out(irq));
  amc_host_model host (.clk_in(clk_in), .rstn_in(rstn_in), .sel_in(sel),
    .oe_n_in(oe_n), .pin_in(pin), .cs_n_out(cs_n), .n_drv_out(n_drv), .bits_out(bits));
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus <= '0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus <= '0;
    #1 d = rdata;
  endtask : rd
  task settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : settle
  task wait_ready();
    int i;
    for (i = 0; i < 500 && data_ready_n_n !== 1'b0; i++) settle(1);
    check({7'h00, data_ready_n_n}, 8'h00);
  endtask : wait_ready
  task t_reset();
    rd(`AMC_OFS_AMP, v);
    check(v, `AMC_RST_AMP);
    rd(`AMC_OFS_INSEL, v);
    check(v, `AMC_RST_INSEL);
    check({byp, 5'h00, gain}, 8'h00);
    check({psel, nsel}, 8'hFF);
    check({7'h00, int_clk}, 8'h01);
    rd(8'h30, v);
    check(v, 8'h00);
  endtask : t_reset
  task t_amp();
    wr(`AMC_OFS_AMP, 8'h80);
    settle(1);
    check({7'h00, byp}, 8'h01);
    wr(`AMC_OFS_AMP, 8'h07);
    settle(1);
    check({byp, 5'h00, gain}, {6'h00, AMC_GAIN_128});
    wr(`AMC_OFS_AMP, 8'h5E);
    settle(1);
    check({6'h00, gain}, {6'h00, AMC_GAIN_64});
    rd(`AMC_OFS_AMP, v);
    check(v, 8'h5E);
    wr(`AMC_OFS_AMP, 8'h03);
    settle(1);
    check({6'h00, gain}, {6'h00, AMC_GAIN_BAD});
    wr(`AMC_OFS_AMP, 8'h00);
    settle(1);
    check({6'h00, gain}, {6'h00, AMC_GAIN_1});
  endtask : t_amp
  task t_mux();
    wr(`AMC_OFS_DELAY, 8'h10);
    wr(`AMC_OFS_INSEL, 8'h38);
    settle(1);
    check({psel, nsel}, 8'h38);
    wr(`AMC_OFS_INSEL, 8'hBE);
    settle(1);
    check({psel, nsel}, 8'hBE);
    wr(`AMC_OFS_INSEL, 8'h92);
    rd(`AMC_OFS_STATUS, v);
    check(v & 8'h02, 8'h02);
    wr(`AMC_OFS_IRQ_CLR, 8'h02);
    wr(`AMC_OFS_INSEL, 8'hFF);
    rd(`AMC_OFS_STATUS, v);
    check(v & 8'h02, 8'h00);
    wr(`AMC_OFS_INSEL, 8'h3D);
    rd(`AMC_OFS_STATUS, v);
    check(v & 8'h02, 8'h02);
    wr(`AMC_OFS_INSEL, 8'hFF);
  endtask : t_mux
  task t_conv();
    wr(`AMC_OFS_IRQ_CLR, 8'hFF);
    wr(`AMC_OFS_IRQ_EN, 8'h01);
    wr(`AMC_OFS_CTRL, 8'h01);
    wait_ready();
    rd(`AMC_OFS_STATUS, v);
    check(v & 8'h01, 8'h01);
    check({7'h00, irq}, 8'h01);
    // first result is one step of the running sum of input_select
    rd(`AMC_OFS_DATA2, v);
    check(v, 8'hFF);
    wr(`AMC_OFS_IRQ_CLR, 8'h01);
    settle(1);
    check({7'h00, irq}, 8'h00);
    check({7'h00, data_ready_n_n}, 8'h01);
    settle(300);
    // command mode: no second result, so the buffer still holds the first
    check({7'h00, data_ready_n_n}, 8'h01);
    rd(`AMC_OFS_DATA2, w);
    check(w, v);
  endtask : t_conv
  task t_cont();
    wr(`AMC_OFS_CTRL, 8'h10);
    start <= 1'b1;
    wait_ready();
    rd(`AMC_OFS_DATA0, v);
    settle(1);
    check({7'h00, data_ready_n_n}, 8'h01);
    wait_ready();
    start <= 1'b0;
    wr(`AMC_OFS_CTRL, 8'h02);
  endtask : t_cont
  task t_pins();
    settle(1);
    check({7'h00, pin}, 8'h00);
    sel <= 1'b1;
    settle(30);
    check({7'h00, oe_n}, 8'h00);
    check({7'h00, n_drv != 8'h00}, 8'h01);
    check({7'h00, bits[24]}, 8'h00);
    rd(`AMC_OFS_DATA0, v);
    check(bits[23:16], v);
    rd(`AMC_OFS_DATA1, v);
    check(bits[15:8], v);
    rd(`AMC_OFS_DATA2, v);
    check(bits[7:0], v);
    sel <= 1'b0;
    settle(3);
    check({7'h00, oe_n}, 8'h01);
    ext_clk <= 1'b1;
    settle(3);
    check({7'h00, int_clk}, 8'h00);
    ext_clk <= 1'b0;
    settle(3);
    check({7'h00, int_clk}, 8'h01);
    pdn_n <= 1'b0;
    settle(3);
    check({7'h00, pd}, 8'h01);
    pdn_n <= 1'b1;
    settle(3);
    check({7'h00, pd}, 8'h00);
  endtask : t_pins
  task t_soft();
    wr(`AMC_OFS_CTRL, 8'h08);
    settle(1);
    check({7'h00, pd}, 8'h01);
    wr(`AMC_OFS_AMP, 8'h86);
    wr(`AMC_OFS_INSEL, 8'h41);
    wr(`AMC_OFS_CTRL, 8'h04);
    settle(2);
    rd(`AMC_OFS_AMP, v);
    check(v, `AMC_RST_AMP);
    rd(`AMC_OFS_INSEL, v);
    check(v, `AMC_RST_INSEL);
    rd(`AMC_OFS_STATUS, v);
    check(v, 8'h00);
  endtask : t_soft
  task complete_run();
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // watchdog sized well above the fewer than one thousand cycles the tests need
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    settle(1);
    t_reset();
    t_amp();
    t_mux();
    t_conv();
    t_cont();
    t_pins();
    t_soft();
    complete_run();
  end
endmodule : tb_amp_and_input_mux_config
